/* pkg/atic_pkg.sv */
// Shared constants, types and register map of the actuator teach-in controller.
package atic_pkg;

  // System clock and the timing figures derived from it.
  localparam int unsigned CLK_HZ           = 10000000;
  localparam int unsigned TEACH_TIME_S     = 60;
  localparam int unsigned TEACH_CYCLES     = TEACH_TIME_S * CLK_HZ;
  localparam int unsigned WAIT_FLASH_HZ    = 4;
  localparam int unsigned TEACH_FLASH_HZ   = 1;
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * WAIT_FLASH_HZ);
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * TEACH_FLASH_HZ);
  localparam int unsigned DARK_SHOW_HALVES = 6;

  // Widths and limits.
  localparam int          CODE_W      = 16;
  localparam int          HIST_DEPTH  = 8;
  localparam logic [3:0]  MAX_TEACH   = 4'h8;
  localparam logic [3:0]  LAST_THREE  = 4'h5;
  localparam logic [3:0]  LAST_TWO    = 4'h6;
  localparam logic [1:0]  FLASH_THREE = 2'h3;
  localparam logic [1:0]  FLASH_TWO   = 2'h2;
  localparam logic [1:0]  FLASH_ONE   = 2'h1;
  localparam logic [3:0]  PAUSE_HALVES = 4'h4;

  // Wishbone register byte offsets and fields.
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_CODE        = 8'h08;
  localparam int          CTRL_TEACH_EN   = 0;
  localparam logic        CTRL_TEACH_EN_RST = 1'b1;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_COUNT_LSB    = 4;
  localparam int          ST_FAULT_LSB    = 8;
  localparam int          ST_CODE_OK      = 12;
  localparam int          ST_ACT_OK       = 13;

  // Main controller states.
  typedef enum logic [2:0] {
    ST_BOOT       = 3'b000,
    ST_SHOW       = 3'b001,
    ST_WAIT_FIRST = 3'b010,
    ST_NORMAL     = 3'b011,
    ST_TEACH      = 3'b100,
    ST_TEACH_DONE = 3'b101,
    ST_FAULT      = 3'b110
  } atic_state_type;

  // Operating fault codes, equal to the repeated flash count.
  typedef enum logic [1:0] {
    FLT_NONE  = 2'b00,
    FLT_NINTH = 2'b01,
    FLT_OLD   = 2'b10,
    FLT_SHORT = 2'b11
  } atic_fault_type;

  // Status indicator patterns.
  typedef enum logic [2:0] {
    FM_OFF          = 3'b000,
    FM_ON           = 3'b001,
    FM_FAST         = 3'b010,
    FM_SLOW         = 3'b011,
    FM_COUNT_ONCE   = 3'b100,
    FM_COUNT_REPEAT = 3'b101
  } atic_flash_mode_type;

endpackage : atic_pkg

/* pkg/atic_flash_if.sv */
// Link between the controller and its status indicator pattern generator.
interface atic_flash_if;
  atic_pkg::atic_flash_mode_type mode;
  logic [1:0]                    count;
  logic                          led;
  logic                          done;

  modport ctrl    (output mode, output count, input led, input done);
  modport flasher (input mode, input count, output led, output done);
endinterface : atic_flash_if

/* logic/atic_flasher.sv */
// Status indicator pattern generator, prescaled from the system clock.
module atic_flasher #(
  parameter int unsigned FAST_HALF = atic_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_HALF = atic_pkg::SLOW_HALF_CYCLES
) (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  atic_flash_if.flasher  fl
);
  logic [31:0]                   tick_cnt;
  logic [31:0]                   half_len;
  logic                          half_tick;
  logic                          restart;
  logic [3:0]                    halves;
  logic [3:0]                    flash_len;
  logic                          in_seq;
  atic_pkg::atic_flash_mode_type last_mode;

  // A new pattern always starts from its first lit half period.
  assign restart   = (fl.mode != last_mode);
  assign half_len  = (fl.mode == atic_pkg::FM_SLOW) ? 32'(SLOW_HALF) : 32'(FAST_HALF);
  assign half_tick = (tick_cnt >= half_len - 32'h1);
  assign flash_len = {1'b0, fl.count, 1'b0};
  assign in_seq    = (halves < flash_len);

  // Prescaler that marks each half flash period.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || restart || half_tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // Remember the pattern to detect a change.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_mode <= atic_pkg::FM_OFF;
    end else begin
      last_mode <= fl.mode;
    end
  end

  // Half period counter; a single count saturates, a repeated one wraps after a pause.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || restart) begin
      halves <= 4'h0;
    end else if (half_tick) begin
      if (fl.mode == atic_pkg::FM_COUNT_REPEAT && halves >= flash_len + atic_pkg::PAUSE_HALVES - 4'h1) begin
        halves <= 4'h0;
      end else if (!(fl.mode == atic_pkg::FM_COUNT_ONCE && !in_seq)) begin
        halves <= halves + 4'h1;
      end
    end
  end

  // Indicator level for each pattern.
  always_comb begin
    case (fl.mode)
      atic_pkg::FM_OFF:          fl.led = 1'b0;
      atic_pkg::FM_ON:           fl.led = 1'b1;
      atic_pkg::FM_FAST,
      atic_pkg::FM_SLOW:         fl.led = ~halves[0];
      atic_pkg::FM_COUNT_ONCE:   fl.led = in_seq ? ~halves[0] : 1'b1;
      atic_pkg::FM_COUNT_REPEAT: fl.led = in_seq & ~halves[0];
      default:                   fl.led = 1'b0;
    endcase
  end

  assign fl.done = (fl.mode == atic_pkg::FM_COUNT_ONCE) && !in_seq && !restart;

endmodule : atic_flasher

/* logic/atic_ctrl.sv */
// Teach-in, safety output and indicator controller with a Wishbone register port.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
module atic_ctrl #(
  parameter int unsigned TEACH_CYCLES = atic_pkg::TEACH_CYCLES,
  parameter int unsigned FAST_HALF    = atic_pkg::FAST_HALF_CYCLES,
  parameter int unsigned SLOW_HALF    = atic_pkg::SLOW_HALF_CYCLES
) (
  // Clock and power-on reset.
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        RST_N_IN,
  // Clear of the nonvolatile store, used only for factory state.
  input  wire logic                        NV_CLR_N_IN,
  // Read head and door.
  input  wire logic                        ACT_PRESENT_IN,
  input  wire logic [atic_pkg::CODE_W-1:0] ACT_CODE_IN,
  input  wire logic                        DOOR_CLOSED_IN,
  // Wishbone slave.
  input  wire logic                        WB_CYC_IN,
  input  wire logic                        WB_STB_IN,
  input  wire logic                        WB_WE_IN,
  input  wire logic [7:0]                  WB_ADR_IN,
  input  wire logic [3:0]                  WB_SEL_IN,
  input  wire logic [31:0]                 WB_DAT_IN,
  output logic      [31:0]                 WB_DAT_OUT,
  output logic                             WB_ACK_OUT,
  // Outputs to the safety control system.
  output logic                             SAFETY_OUTPUT_A_OUT,
  output logic                             SAFETY_OUTPUT_B_OUT,
  output logic                             DOOR_STATUS_OUT,
  // Indicators.
  output logic                             STATE_LED_OUT,
  output logic                             OUT_LED_OUT,
  output logic                             ERROR_LED_OUT
);
  localparam logic [31:0] TEACH_LAST = 32'(TEACH_CYCLES - 1);
  localparam logic [31:0] DARK_LAST  = 32'(FAST_HALF * atic_pkg::DARK_SHOW_HALVES - 1);

  atic_pkg::atic_state_type        state;
  atic_pkg::atic_state_type        next_state;
  atic_pkg::atic_fault_type        fault;
  atic_pkg::atic_fault_type        next_fault;
  atic_pkg::atic_fault_type        teach_fault;
  logic [atic_pkg::CODE_W-1:0]     active_code;
  logic [atic_pkg::CODE_W-1:0]     pending_code;
  logic [atic_pkg::CODE_W-1:0]     teach_code;
  logic [atic_pkg::CODE_W-1:0]     hist [atic_pkg::HIST_DEPTH];
  logic                            active_valid;
  logic                            pending_valid;
  logic                            teach_busy;
  logic [3:0]                      teach_count;
  logic                            teach_store;
  logic [31:0]                     timer;
  logic                            door_seen_open;
  logic                            teach_en;
  logic                            act_valid;
  logic                            old_code;
  logic                            safe_on;
  logic                            start_go;
  logic                            start_store;
  atic_pkg::atic_fault_type        start_fault;
  logic                            finish_go;

  atic_flash_if fl ();

  atic_flasher #(
    .FAST_HALF (FAST_HALF),
    .SLOW_HALF (SLOW_HALF)
  ) u_flasher (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .fl       (fl.flasher)
  );

  // Only the active code of a taught actuator counts; anything else is absent.
  assign act_valid = ACT_PRESENT_IN && active_valid && (ACT_CODE_IN == active_code);
  assign finish_go = (state == atic_pkg::ST_TEACH) && DOOR_CLOSED_IN && ACT_PRESENT_IN
                     && (ACT_CODE_IN == teach_code) && (timer == TEACH_LAST) && teach_store;

  // An old actuator is one taught earlier but no longer active.
  always_comb begin
    old_code = 1'b0;
    for (int i = 0; i < atic_pkg::HIST_DEPTH; i++) begin
      if (4'(i) < teach_count && hist[i] == ACT_CODE_IN && !act_valid) begin
        old_code = 1'b1;
      end
    end
  end

  // Teach-in start decision and the kind of teach-in it becomes.
  always_comb begin
    start_go    = ACT_PRESENT_IN && DOOR_CLOSED_IN && teach_en && !act_valid
                  && (state == atic_pkg::ST_WAIT_FIRST || state == atic_pkg::ST_NORMAL);
    start_store = 1'b1;
    start_fault = atic_pkg::FLT_NONE;
    if (old_code) begin
      start_store = 1'b0;
      start_fault = atic_pkg::FLT_OLD;
    end else if (teach_count >= atic_pkg::MAX_TEACH) begin
      start_store = 1'b0;
      start_fault = atic_pkg::FLT_NINTH;
    end
  end

  // Next state and fault code.
  always_comb begin
    next_state = state;
    next_fault = fault;
    case (state)
      atic_pkg::ST_BOOT: begin
        if (teach_busy) begin
          next_state = atic_pkg::ST_FAULT;
          next_fault = atic_pkg::FLT_SHORT;
        end else if (teach_count == 4'h0 && !pending_valid) begin
          next_state = atic_pkg::ST_WAIT_FIRST;
        end else begin
          next_state = atic_pkg::ST_SHOW;
        end
      end
      atic_pkg::ST_SHOW: begin
        if (fl.done || (teach_count >= atic_pkg::MAX_TEACH && timer >= DARK_LAST)) begin
          next_state = atic_pkg::ST_NORMAL;
        end
      end
      atic_pkg::ST_WAIT_FIRST,
      atic_pkg::ST_NORMAL: begin
        if (start_go) begin
          next_state = atic_pkg::ST_TEACH;
        end
      end
      atic_pkg::ST_TEACH: begin
        if (!DOOR_CLOSED_IN || !ACT_PRESENT_IN || ACT_CODE_IN != teach_code) begin
          next_state = atic_pkg::ST_FAULT;
          next_fault = atic_pkg::FLT_SHORT;
        end else if (timer == TEACH_LAST) begin
          next_state = teach_store ? atic_pkg::ST_TEACH_DONE : atic_pkg::ST_FAULT;
          next_fault = teach_fault;
        end
      end
      atic_pkg::ST_TEACH_DONE: begin
        next_state = atic_pkg::ST_TEACH_DONE;
      end
      atic_pkg::ST_FAULT: begin
        if (door_seen_open && DOOR_CLOSED_IN) begin
          next_state = (teach_count == 4'h0) ? atic_pkg::ST_WAIT_FIRST : atic_pkg::ST_NORMAL;
          next_fault = atic_pkg::FLT_NONE;
        end
      end
      default: begin
        next_state = atic_pkg::ST_BOOT;
      end
    endcase
  end

  // State register; a power cycle restarts at boot and drops any latched fault.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state <= atic_pkg::ST_BOOT;
      fault <= atic_pkg::FLT_NONE;
    end else begin
      state <= next_state;
      fault <= next_fault;
    end
  end

  // Shared timer for teach-in length and the dark power-up display.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || state != next_state) begin
      timer <= 32'h0;
    end else if (timer != 32'hffff_ffff) begin
      timer <= timer + 32'h1;
    end
  end

  // Teach-in session bookkeeping.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      teach_code  <= '0;
      teach_store <= 1'b0;
      teach_fault <= atic_pkg::FLT_NONE;
    end else if (start_go) begin
      teach_code  <= ACT_CODE_IN;
      teach_store <= start_store;
      teach_fault <= start_fault;
    end
  end

  // Guard must be seen open before a fault may clear.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || state != atic_pkg::ST_FAULT) begin
      door_seen_open <= 1'b0;
    end else if (!DOOR_CLOSED_IN) begin
      door_seen_open <= 1'b1;
    end
  end

  // Nonvolatile store; survives the power-on reset, only a factory clear empties it.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NV_CLR_N_IN) begin
      active_code   <= '0;
      active_valid  <= 1'b0;
      pending_code  <= '0;
      pending_valid <= 1'b0;
      teach_busy    <= 1'b0;
      teach_count   <= 4'h0;
      for (int i = 0; i < atic_pkg::HIST_DEPTH; i++) begin
        hist[i] <= '0;
      end
    end else if (RST_N_IN) begin
      if (state == atic_pkg::ST_BOOT) begin
        teach_busy <= 1'b0;
        if (!teach_busy && pending_valid) begin
          active_code   <= pending_code;
          active_valid  <= 1'b1;
          pending_valid <= 1'b0;
        end
      end else if (start_go) begin
        teach_busy <= 1'b1;
      end else if (finish_go) begin
        teach_busy    <= 1'b0;
        pending_code  <= teach_code;
        pending_valid <= 1'b1;
        hist[teach_count[2:0]] <= teach_code;
        teach_count   <= teach_count + 4'h1;
      end else if (state == atic_pkg::ST_FAULT || state == atic_pkg::ST_TEACH_DONE) begin
        teach_busy <= 1'b0;
      end
    end
  end

  // Status indicator pattern for each state.
  always_comb begin
    fl.mode  = atic_pkg::FM_ON;
    fl.count = atic_pkg::FLASH_THREE;
    case (state)
      atic_pkg::ST_BOOT:       fl.mode = atic_pkg::FM_OFF;
      atic_pkg::ST_SHOW: begin
        fl.mode = atic_pkg::FM_COUNT_ONCE;
        if (teach_count >= atic_pkg::MAX_TEACH) begin
          fl.mode = atic_pkg::FM_OFF;
        end else if (teach_count > atic_pkg::LAST_TWO) begin
          fl.count = atic_pkg::FLASH_ONE;
        end else if (teach_count > atic_pkg::LAST_THREE) begin
          fl.count = atic_pkg::FLASH_TWO;
        end
      end
      atic_pkg::ST_WAIT_FIRST: fl.mode = atic_pkg::FM_FAST;
      atic_pkg::ST_NORMAL:     fl.mode = atic_pkg::FM_ON;
      atic_pkg::ST_TEACH:      fl.mode = atic_pkg::FM_SLOW;
      atic_pkg::ST_TEACH_DONE: fl.mode = atic_pkg::FM_OFF;
      atic_pkg::ST_FAULT: begin
        fl.mode  = atic_pkg::FM_COUNT_REPEAT;
        fl.count = fault;
      end
      default:                 fl.mode = atic_pkg::FM_OFF;
    endcase
  end

  // Outputs are on only in normal operation with door closed and the active actuator.
  assign safe_on = (state == atic_pkg::ST_NORMAL) && act_valid && DOOR_CLOSED_IN;

  // Registered pins; every other state holds them in the safe state.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      SAFETY_OUTPUT_A_OUT <= 1'b0;
      SAFETY_OUTPUT_B_OUT <= 1'b0;
      DOOR_STATUS_OUT     <= 1'b0;
      OUT_LED_OUT         <= 1'b0;
      ERROR_LED_OUT       <= 1'b0;
      STATE_LED_OUT       <= 1'b0;
    end else begin
      SAFETY_OUTPUT_A_OUT <= safe_on;
      SAFETY_OUTPUT_B_OUT <= safe_on;
      DOOR_STATUS_OUT     <= safe_on;
      OUT_LED_OUT         <= safe_on;
      ERROR_LED_OUT       <= (state == atic_pkg::ST_FAULT);
      STATE_LED_OUT       <= fl.led;
    end
  end

  // Wishbone slave: answer one cycle after the request, write takes effect with ack.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    end
  end

  // Control register; unmapped writes are acknowledged and dropped.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      teach_en <= atic_pkg::CTRL_TEACH_EN_RST;
    end else if (WB_ACK_OUT && WB_CYC_IN && WB_STB_IN && WB_WE_IN
                 && WB_ADR_IN == atic_pkg::REG_CTRL && WB_SEL_IN[0]) begin
      teach_en <= WB_DAT_IN[atic_pkg::CTRL_TEACH_EN];
    end
  end

  // Read data is captured with the request; unmapped reads return zero.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      WB_DAT_OUT <= 32'h0;
    end else if (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) begin
      WB_DAT_OUT <= 32'h0;
      case (WB_ADR_IN)
        atic_pkg::REG_CTRL:   WB_DAT_OUT[atic_pkg::CTRL_TEACH_EN] <= teach_en;
        atic_pkg::REG_STATUS: begin
          WB_DAT_OUT[atic_pkg::ST_STATE_LSB +: 3] <= state;
          WB_DAT_OUT[atic_pkg::ST_COUNT_LSB +: 4] <= teach_count;
          WB_DAT_OUT[atic_pkg::ST_FAULT_LSB +: 2] <= fault;
          WB_DAT_OUT[atic_pkg::ST_CODE_OK]        <= active_valid;
          WB_DAT_OUT[atic_pkg::ST_ACT_OK]         <= act_valid;
        end
        atic_pkg::REG_CODE:   WB_DAT_OUT[atic_pkg::CODE_W-1:0] <= active_code;
        default:              WB_DAT_OUT <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence wb_req_s;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence wb_answer_s;
    ##1 WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  sequence teach_end_s;
    finish_go;
  endsequence
  sequence done_dark_s;
    ##1 (state == atic_pkg::ST_TEACH_DONE) ##1 !STATE_LED_OUT [*2];
  endsequence

  wb_single_ack_a: assert property (wb_req_s |-> wb_answer_s)
    else $error("Wishbone ack not a single pulse one cycle after request");
  teach_outputs_off_a: assert property ((state == atic_pkg::ST_TEACH) |=>
    !SAFETY_OUTPUT_A_OUT && !SAFETY_OUTPUT_B_OUT && !DOOR_STATUS_OUT)
    else $error("Outputs not safe during teach-in");
  fault_error_led_a: assert property ((state == atic_pkg::ST_FAULT) |=> ERROR_LED_OUT)
    else $error("Error indicator dark in fault state");
  teach_limit_a: assert property (teach_count <= atic_pkg::MAX_TEACH)
    else $error("Teach-in count above limit");
  code_deferred_a: assert property (finish_go |=>
    pending_valid && active_code == $past(active_code))
    else $error("New code activated before power cycle");
  unknown_absent_a: assert property (!act_valid |=> !SAFETY_OUTPUT_A_OUT && !OUT_LED_OUT)
    else $error("Untaught actuator switched outputs on");
  closed_outputs_on_a: assert property (safe_on |=>
    SAFETY_OUTPUT_A_OUT && SAFETY_OUTPUT_B_OUT && DOOR_STATUS_OUT && OUT_LED_OUT)
    else $error("Outputs off with door closed and valid actuator");
  open_outputs_off_a: assert property ((state == atic_pkg::ST_NORMAL && !DOOR_CLOSED_IN) |=>
    !SAFETY_OUTPUT_A_OUT && !DOOR_STATUS_OUT && !OUT_LED_OUT && !ERROR_LED_OUT)
    else $error("Outputs on with door open");
  wait_first_safe_a: assert property ((state == atic_pkg::ST_WAIT_FIRST) |=>
    !SAFETY_OUTPUT_B_OUT && !DOOR_STATUS_OUT)
    else $error("Outputs on before first teach-in");
  teach_done_dark_a: assert property (teach_end_s |-> done_dark_s)
    else $error("Status indicator not dark after teach-in completed");

endmodule : atic_ctrl

/* bench/atic_partner.sv */
// Model of the coded actuator, the door and the downstream safety control system.
module atic_partner (
  // Commands from the bench.
  input  wire logic        clk_in,
  input  wire logic        place_in,
  input  wire logic [15:0] code_in,
  input  wire logic        close_in,
  input  wire logic        start_in,
  // Safety outputs as the control system sees them.
  input  wire logic        out_a_in,
  input  wire logic        out_b_in,
  // Read head, door and machine.
  output logic             present_out,
  output logic [15:0]      code_out,
  output logic             closed_out,
  output logic             run_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // An absent actuator leaves no stable code, so the head sees the inverse pattern.
  assign present_out = place_in;
  assign code_out    = place_in ? code_in : ~code_in;
  assign closed_out  = close_in;
  // The machine runs only after an explicit start with both outputs on, never by itself.
  always_ff @(posedge clk_in) run_out <= out_a_in & out_b_in & (run_out | start_in);
endmodule : atic_partner

/* bench/actuator_teach_in_controller_bench.sv */
// Self-checking bench for the teach-in controller.
module actuator_teach_in_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 200;
  logic        clk = 1'b0, rst_n = 1'b0, nvclr_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        place = 1'b0, close = 1'b0, start = 1'b0;
  logic        ack, a, b, ds, sled, oled, eled, present, closed, run;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [15:0] code = 16'h0000, acode;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          err_total = 0, tests_run = 0, ncyc = 0, f;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  // Design under test and its far side.
  atic_ctrl #(.TEACH_CYCLES(TC), .FAST_HALF(4), .SLOW_HALF(8)) i_dut (.SYS_CLK_IN(clk),
    .RST_N_IN(rst_n), .NV_CLR_N_IN(nvclr_n), .ACT_PRESENT_IN(present), .ACT_CODE_IN(acode),
    .DOOR_CLOSED_IN(closed), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .SAFETY_OUTPUT_A_OUT(a), .SAFETY_OUTPUT_B_OUT(b), .DOOR_STATUS_OUT(ds),
    .STATE_LED_OUT(sled), .OUT_LED_OUT(oled), .ERROR_LED_OUT(eled));
  atic_partner i_partner (.clk_in(clk), .place_in(place), .code_in(code), .close_in(close),
    .start_in(start), .out_a_in(a), .out_b_in(b), .present_out(present), .code_out(acode),
    .closed_out(closed), .run_out(run));
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Classic single Wishbone cycle; holds the request until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    chk("wishbone latency", 32'h2, n); // The slave answers one cycle after it takes the request.
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Power interruption; the long reset stands for the off time.
  task automatic power_cycle();
    rst_n <= 1'b0;
    repeat (30) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : power_cycle
  // Counts falling edges of the status light over n cycles.
  task automatic falls(input int n);
    logic p;
    f = 0;
    p = sled;
    repeat (n) begin
      @(posedge clk);
      if (p === 1'b1 && sled === 1'b0) f++;
      p = sled;
    end
  endtask : falls
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // Hang guard; the whole sequence needs about 1,100 cycles.
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  // Factory state: the block waits for a first actuator with fast flashing.
  task automatic test_factory();
    wb(1'b0, 8'h04, 32'h0);
    chk("wait state", 32'h2, q[2:0]);
    chk("outputs idle", 3'b000, {a, b, ds});
    falls(64);
    chk("fast flash", 1, f >= 7 && f <= 9);
    $display("factory test done");
  endtask : test_factory
  // First teach-in with the door closed, up to the dark acknowledgment.
  task automatic test_first_teach();
    place <= 1'b1;
    code <= 16'h1234;
    close <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("teach state", 32'h4, q[2:0]);
    chk("outputs teach", 3'b000, {a, b, ds});
    falls(64);
    chk("slow flash", 1, f >= 3 && f <= 5);
    repeat (TC) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("teach done", 32'h5, q[2:0]);
    chk("teach count", 32'h1, q[7:4]);
    chk("done light", 4'h0, {sled, a, b, ds});
    $display("teach test done");
  endtask : test_first_teach
  // Power-up display, code activation, an explicit machine start and a door opening.
  task automatic test_activation();
    power_cycle();
    falls(80);
    chk("count flashes", 3, f);
    wb(1'b0, 8'h08, 32'h0);
    chk("active code", 32'h1234, q);
    chk("closed valid", 4'hf, {a, b, ds, oled});
    chk("no auto start", 1'b0, run);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk("machine runs", 1'b1, run);
    close <= 1'b0;
    repeat (3) @(posedge clk);
    chk("door open", 6'h20, {sled, a, b, ds, oled, eled});
    chk("machine stops", 1'b0, run);
    $display("activation test done");
  endtask : test_activation
  // An untaught actuator stays absent while teach-in is disabled.
  task automatic test_unknown();
    wb(1'b1, 8'h00, 32'h0);
    code <= 16'h5a5a;
    close <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("unknown code", 32'h3, {q[13], q[2:0]});
    chk("unknown outputs", 3'b000, {a, b, ds});
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped read", 32'h0, q);
    $display("unknown code test done");
  endtask : test_unknown
  // Opening the door during teach-in latches a fault; open and close clears it.
  task automatic test_fault();
    wb(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge clk);
    close <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("fault state", 32'h36, {q[9:8], q[3:0]});
    chk("error light", 1, eled);
    place <= 1'b0;
    close <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("fault cleared", 32'h3, {eled, q[2:0]});
    $display("fault test done");
  endtask : test_fault
  // Second teach-in, then an earlier actuator runs a full cycle that stores nothing.
  task automatic test_old_actuator();
    place <= 1'b1;
    repeat (TC + 4) @(posedge clk);
    power_cycle();
    falls(80);
    chk("second count flashes", 3, f);
    code <= 16'h1234;
    repeat (TC + 4) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk("old fault", 32'h116, {q[9:8], q[7:4], q[2:0]});
    chk("old fault light", 1, eled);
    falls(64);
    chk("old fault flashes", 4, f);
    wb(1'b0, 8'h08, 32'h0);
    chk("code kept", 32'h5a5a, q);
    $display("old actuator test done");
  endtask : test_old_actuator
  // Factory reset, then the scenarios in order; each leaves the state the next one needs.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    nvclr_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_factory();
    test_first_teach();
    test_activation();
    test_unknown();
    test_fault();
    test_old_actuator();
    give_verdict();
  end
endmodule : actuator_teach_in_controller_bench
